// File: hdl/tcu_timer8.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_timer8 #(
   parameter int WIDTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_timer_tick,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic [2:0] i_irq_ack,
   output logic [2:0] o_irq_req,
   output logic [WIDTH-1:0] o_count_value,
   output logic o_wave_out_a,
   output logic o_wave_out_a_oe,
   output logic o_wave_out_b,
   output logic o_wave_out_b_oe
);
   logic [WIDTH-1:0] count_value_r;
   logic [WIDTH-1:0] count_value_nxt;
   logic count_down_r;
   logic [WIDTH-1:0] cmp_act_r [2];
   logic [WIDTH-1:0] cmp_buf_r [2];
   logic [1:0] action_r [2];
   logic [2:0] wave_mode_field;
   logic [2:0] tick_source_select_r;
   logic [2:0] irq_mask_r;
   logic [2:0] irq_flag_r;
   logic [3:0] pin_ctrl_r;
   logic [1:0] wave_r;
   logic [1:0] wave_mode_lo_r;
   logic wave_mode_hi_r;
   logic block_r;
   logic acc_wr;
   logic acc_rd;
   logic wr_count;
   logic tick;
   logic pwm_mode;
   logic phase_mode;
   logic [WIDTH-1:0] top_val;
   logic at_top;
   logic at_bottom;
   logic [1:0] match;
   logic [1:0] force_hit;
   logic ovf_set;
   logic [31:0] rd_mux;
   logic addr_ok;

   assign wave_mode_field = {wave_mode_hi_r, wave_mode_lo_r};
   assign tick = i_ce && i_timer_tick && (tick_source_select_r != 3'h0);
   assign acc_wr = i_psel && i_penable && i_pwrite && o_pready;
   assign acc_rd = i_psel && !i_penable && !i_pwrite;
   assign wr_count = i_ce && acc_wr && (i_paddr == tcu_pkg::ADDR_COUNT);
   assign pwm_mode = (wave_mode_field == tcu_pkg::WM_PC_FF) || (wave_mode_field == tcu_pkg::WM_FAST_FF)
      || (wave_mode_field == tcu_pkg::WM_PC_CMP) || (wave_mode_field == tcu_pkg::WM_FAST_CMP);
   assign phase_mode = (wave_mode_field == tcu_pkg::WM_PC_FF) || (wave_mode_field == tcu_pkg::WM_PC_CMP);
   // top is either max or compare a, by mode
   assign top_val = ((wave_mode_field == tcu_pkg::WM_CTC) || (wave_mode_field == tcu_pkg::WM_PC_CMP)
      || (wave_mode_field == tcu_pkg::WM_FAST_CMP)) ? cmp_act_r[0] : tcu_pkg::MAX_VAL;
   assign at_top = (count_value_r == top_val);
   assign at_bottom = (count_value_r == tcu_pkg::BOTTOM_VAL);

   ////////////////////////////////////////////////////////////////////////////
   // counter unit
   always_comb begin
      count_value_nxt = count_value_r;
      ovf_set = 1'b0;
      if (tick) begin
         unique case (wave_mode_field)
            tcu_pkg::WM_NORMAL: begin
               count_value_nxt = count_value_r + 1'b1;
               ovf_set = (count_value_r == tcu_pkg::MAX_VAL);
            end
            tcu_pkg::WM_CTC: begin
               count_value_nxt = at_top ? tcu_pkg::BOTTOM_VAL : count_value_r + 1'b1;
               ovf_set = (count_value_r == tcu_pkg::MAX_VAL);
            end
            tcu_pkg::WM_FAST_FF, tcu_pkg::WM_FAST_CMP: begin
               count_value_nxt = at_top ? tcu_pkg::BOTTOM_VAL : count_value_r + 1'b1;
               ovf_set = at_top;
            end
            tcu_pkg::WM_PC_FF, tcu_pkg::WM_PC_CMP: begin
               if (count_down_r && !at_bottom) begin
                  count_value_nxt = count_value_r - 1'b1;
               end else if (at_top) begin
                  count_value_nxt = count_value_r - 1'b1;
               end else begin
                  count_value_nxt = count_value_r + 1'b1;
               end
               ovf_set = at_bottom && count_down_r;
            end
            default: begin
               // reserved modes hold the counter
               count_value_nxt = count_value_r;
            end
         endcase
      end
      if (wr_count) begin
         count_value_nxt = i_pwdata[WIDTH-1:0];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count_value_r <= tcu_pkg::RESET_BYTE;
      end else begin
         count_value_r <= count_value_nxt;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count_down_r <= 1'b0;
      end else if (i_ce && !phase_mode) begin
         count_down_r <= 1'b0;
      end else if (tick) begin
         if (at_top) begin
            count_down_r <= 1'b1;
         end else if (at_bottom) begin
            count_down_r <= 1'b0;
         end
      end
   end

   // blocks matches until the next tick has passed, even if the timer is stopped
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         block_r <= 1'b0;
      end else if (wr_count) begin
         block_r <= 1'b1;
      end else if (tick) begin
         block_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare channels
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         logic [7:0] cmp_addr;
         assign cmp_addr = (ch == 0) ? tcu_pkg::ADDR_CMP_A : tcu_pkg::ADDR_CMP_B;
         assign match[ch] = tick && !block_r && (count_value_r == cmp_act_r[ch]);
         assign force_hit[ch] = i_ce && acc_wr && (i_paddr == tcu_pkg::ADDR_CTRL_B) && !pwm_mode
            && i_pwdata[(ch == 0) ? tcu_pkg::FORCE_A_POS : tcu_pkg::FORCE_B_POS];

         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               cmp_buf_r[ch] <= tcu_pkg::RESET_BYTE;
            end else if (i_ce && acc_wr && (i_paddr == cmp_addr)) begin
               cmp_buf_r[ch] <= i_pwdata[WIDTH-1:0];
            end
         end

         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               cmp_act_r[ch] <= tcu_pkg::RESET_BYTE;
            end else if (i_ce && !pwm_mode && acc_wr && (i_paddr == cmp_addr)) begin
               cmp_act_r[ch] <= i_pwdata[WIDTH-1:0];
            end else if (tick && pwm_mode && (phase_mode ? at_top : at_bottom)) begin
               cmp_act_r[ch] <= cmp_buf_r[ch];
            end
         end

         // wave output register; untouched by a mode change
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               wave_r[ch] <= 1'b0;
            end else if (force_hit[ch] || (match[ch] && !pwm_mode)) begin
               unique case (action_r[ch])
                  2'h0: wave_r[ch] <= wave_r[ch];
                  2'h1: wave_r[ch] <= !wave_r[ch];
                  2'h2: wave_r[ch] <= 1'b0;
                  2'h3: wave_r[ch] <= 1'b1;
               endcase
            end else if (match[ch] && pwm_mode && action_r[ch][1]) begin
               // pwm: clear on match (non-inverted), set when inverted; down-slope mirrors it
               wave_r[ch] <= action_r[ch][0] ^ (phase_mode && count_down_r);
            end else if (match[ch] && pwm_mode && action_r[ch] == 2'h1 && ch == 0
               && wave_mode_hi_r) begin
               wave_r[ch] <= !wave_r[ch];
            end else if (tick && pwm_mode && !phase_mode && at_top && action_r[ch][1]) begin
               wave_r[ch] <= !action_r[ch][0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // register file
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         action_r[0] <= 2'h0;
         action_r[1] <= 2'h0;
         wave_mode_lo_r <= 2'h0;
      end else if (i_ce && acc_wr && (i_paddr == tcu_pkg::ADDR_CTRL_A)) begin
         action_r[0] <= i_pwdata[tcu_pkg::ACT_A_POS +: 2];
         action_r[1] <= i_pwdata[tcu_pkg::ACT_B_POS +: 2];
         wave_mode_lo_r <= i_pwdata[tcu_pkg::WAVE_LO_POS +: 2];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wave_mode_hi_r <= 1'b0;
         tick_source_select_r <= 3'h0;
      end else if (i_ce && acc_wr && (i_paddr == tcu_pkg::ADDR_CTRL_B)) begin
         wave_mode_hi_r <= i_pwdata[tcu_pkg::WAVE_HI_POS];
         tick_source_select_r <= i_pwdata[tcu_pkg::TICK_SEL_POS +: 3];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_mask_r <= 3'h0;
         pin_ctrl_r <= 4'h0;
      end else if (i_ce && acc_wr) begin
         if (i_paddr == tcu_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= i_pwdata[2:0];
         end
         if (i_paddr == tcu_pkg::ADDR_PIN_CTRL) begin
            pin_ctrl_r <= i_pwdata[3:0];
         end
      end
   end

   // sticky flags: a hardware set wins over a clear in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_flag_r <= 3'h0;
      end else if (i_ce) begin
         irq_flag_r <= (irq_flag_r
            & ~((acc_wr && (i_paddr == tcu_pkg::ADDR_IRQ_FLAG)) ? i_pwdata[2:0] : 3'h0)
            & ~i_irq_ack)
            | {match[1], match[0], ovf_set};
      end
   end

   assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr <= tcu_pkg::ADDR_PIN_CTRL);
   always_comb begin
      rd_mux = 32'h0;
      unique case (i_paddr)
         tcu_pkg::ADDR_CTRL_A: rd_mux = {24'h0, action_r[0], action_r[1], 2'h0, wave_mode_lo_r};
         tcu_pkg::ADDR_CTRL_B: rd_mux = {28'h0, wave_mode_hi_r, tick_source_select_r};
         tcu_pkg::ADDR_COUNT: rd_mux = {24'h0, count_value_r};
         tcu_pkg::ADDR_CMP_A: rd_mux = {24'h0, pwm_mode ? cmp_buf_r[0] : cmp_act_r[0]};
         tcu_pkg::ADDR_CMP_B: rd_mux = {24'h0, pwm_mode ? cmp_buf_r[1] : cmp_act_r[1]};
         tcu_pkg::ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
         tcu_pkg::ADDR_IRQ_FLAG: rd_mux = {29'h0, irq_flag_r};
         tcu_pkg::ADDR_PIN_CTRL: rd_mux = {28'h0, pin_ctrl_r};
         default: rd_mux = 32'h0;
      endcase
   end

   // apb: read data registered in setup, pready one cycle later (no wait state)
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0;
         o_pslverr <= 1'b0;
      end else if (i_ce) begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !addr_ok;
         if (acc_rd) begin
            o_prdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs and pin override
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_req <= 3'h0;
         o_count_value <= tcu_pkg::RESET_BYTE;
         o_wave_out_a <= 1'b0;
         o_wave_out_b <= 1'b0;
         o_wave_out_a_oe <= 1'b0;
         o_wave_out_b_oe <= 1'b0;
      end else if (i_ce) begin
         o_irq_req <= irq_flag_r & irq_mask_r;
         o_count_value <= count_value_r;
         o_wave_out_a <= (action_r[0] != 2'h0) ? wave_r[0] : pin_ctrl_r[tcu_pkg::PORT_A_POS];
         o_wave_out_b <= (action_r[1] != 2'h0) ? wave_r[1] : pin_ctrl_r[tcu_pkg::PORT_B_POS];
         o_wave_out_a_oe <= pin_ctrl_r[tcu_pkg::DIR_A_POS];
         o_wave_out_b_oe <= pin_ctrl_r[tcu_pkg::DIR_B_POS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_stop_holds: assert property (@(posedge i_clk) disable iff (i_rst)
      (tick_source_select_r == 3'h0 && !wr_count) |=> $stable(count_value_r))
      else $error("counter moved while stopped");
   a_write_wins: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_count |=> count_value_r == $past(i_pwdata[WIDTH-1:0]))
      else $error("counter write lost");
   a_normal_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
      (tick && !wr_count && wave_mode_field == 3'h0) |=> count_value_r == $past(count_value_r) + 8'h01)
      else $error("normal mode did not count up");
   a_ovf_normal: assert property (@(posedge i_clk) disable iff (i_rst)
      (tick && wave_mode_field == 3'h0 && count_value_r == 8'hFF) |=> irq_flag_r[0])
      else $error("overflow flag not set");
   // the tick cycle itself must be covered, so the bound is inclusive
   a_block_match: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_count |=> (match == 2'h0) until_with tick)
      else $error("match after counter write");
   a_force_noflag: assert property (@(posedge i_clk) disable iff (i_rst)
      (force_hit[0] && !match[0] && !irq_flag_r[1]) |=> !irq_flag_r[1])
      else $error("force set a flag");
   a_flag_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_irq_ack[1] && !match[0]) |=> !irq_flag_r[1])
      else $error("ack did not clear flag");
   a_idle_keep: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && action_r[0] == 2'h0 && !force_hit[0]) |=> $stable(wave_r[0]))
      else $error("wave changed with action zero");
   a_pin_dir: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_wave_out_a_oe == $past(pin_ctrl_r[tcu_pkg::DIR_A_POS]))
      else $error("direction not followed");
   a_ovf_fast: assert property (@(posedge i_clk) disable iff (i_rst)
      (tick && at_top && (wave_mode_field == tcu_pkg::WM_FAST_FF || wave_mode_field == tcu_pkg::WM_FAST_CMP))
      |=> irq_flag_r[tcu_pkg::IRQ_OVF_POS])
      else $error("fast mode overflow flag not set at top");
   a_ctc_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      (tick && !wr_count && wave_mode_field == tcu_pkg::WM_CTC && at_top)
      |=> count_value_r == tcu_pkg::BOTTOM_VAL)
      else $error("clear-on-match did not restart at compare a");
   a_buf_only: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && acc_wr && pwm_mode && !tick && i_paddr == tcu_pkg::ADDR_CMP_B) |=> $stable(cmp_act_r[1]))
      else $error("buffered compare write reached active value");
   a_cmp_direct: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && acc_wr && !pwm_mode && i_paddr == tcu_pkg::ADDR_CMP_A) |=> cmp_act_r[0] == $past(i_pwdata[WIDTH-1:0]))
      else $error("unbuffered compare write not applied");
   a_match_flag: assert property (@(posedge i_clk) disable iff (i_rst)
      (tick && !block_r && count_value_r == cmp_act_r[1]) |=> irq_flag_r[tcu_pkg::IRQ_CMPB_POS])
      else $error("compare b match did not set flag");
   a_port_pass: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && action_r[0] == 2'h0) |=> o_wave_out_a == $past(pin_ctrl_r[tcu_pkg::PORT_A_POS]))
      else $error("port level not passed with action zero");
   a_irq_follow: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_irq_req == ($past(irq_flag_r) & $past(irq_mask_r)))
      else $error("interrupt request does not follow flag and mask");
endmodule // tcu_timer8
`default_nettype wire

// File: hdl/tcu_pkg.sv
package tcu_pkg;
   // register byte addresses on the apb bus
   localparam logic [7:0] ADDR_CTRL_A = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam logic [7:0] ADDR_CMP_A = 8'h0C;
   localparam logic [7:0] ADDR_CMP_B = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_IRQ_FLAG = 8'h18;
   localparam logic [7:0] ADDR_PIN_CTRL = 8'h1C;
   // control_reg_a fields
   localparam int ACT_A_POS = 6;
   localparam int ACT_B_POS = 4;
   localparam int WAVE_LO_POS = 0;
   // control_reg_b fields
   localparam int FORCE_A_POS = 7;
   localparam int FORCE_B_POS = 6;
   localparam int WAVE_HI_POS = 3;
   localparam int TICK_SEL_POS = 0;
   // irq flag / mask bit positions
   localparam int IRQ_OVF_POS = 0;
   localparam int IRQ_CMPA_POS = 1;
   localparam int IRQ_CMPB_POS = 2;
   // pin control: direction bits and general port levels
   localparam int DIR_A_POS = 0;
   localparam int DIR_B_POS = 1;
   localparam int PORT_A_POS = 2;
   localparam int PORT_B_POS = 3;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] MAX_VAL = 8'hFF;
   localparam logic [7:0] BOTTOM_VAL = 8'h00;
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_PC_FF = 3'h1;
   localparam logic [2:0] WM_CTC = 3'h2;
   localparam logic [2:0] WM_FAST_FF = 3'h3;
   localparam logic [2:0] WM_PC_CMP = 3'h5;
   localparam logic [2:0] WM_FAST_CMP = 3'h7;
endpackage

// File: tb/tcu_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_load (
   input wire logic i_clk,
   input wire logic i_drive_a,
   input wire logic i_oe_a,
   input wire logic i_drive_b,
   input wire logic i_oe_b,
   output logic o_level_a,
   output logic o_level_b
);
   logic last_a_r = 1'b0;
   logic last_b_r = 1'b0;
   ////////////////////////////////////////////////////////////
   // an undriven pin floats: show a changing level so a stale value never looks valid
   always @(posedge i_clk) begin
      last_a_r <= o_level_a;
      last_b_r <= o_level_b;
   end
   assign o_level_a = i_oe_a ? i_drive_a : ~last_a_r;
   assign o_level_b = i_oe_b ? i_drive_b : ~last_b_r;
endmodule // tcu_pin_load
`default_nettype wire

// File: tb/tcu_timer8_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_timer8_tb;
   localparam logic [7:0] CNT = tcu_pkg::ADDR_COUNT;
   localparam logic [7:0] CTA = tcu_pkg::ADDR_CTRL_A;
   localparam logic [7:0] CTB = tcu_pkg::ADDR_CTRL_B;
   localparam logic [7:0] CMA = tcu_pkg::ADDR_CMP_A;
   localparam logic [7:0] CMB = tcu_pkg::ADDR_CMP_B;
   localparam logic [7:0] MSK = tcu_pkg::ADDR_IRQ_MASK;
   localparam logic [7:0] FLG = tcu_pkg::ADDR_IRQ_FLAG;
   localparam logic [7:0] PIN = tcu_pkg::ADDR_PIN_CTRL;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   logic i_timer_tick = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic [2:0] i_irq_ack = 3'h0;
   logic o_pready, o_pslverr, o_wave_out_a, o_wave_out_a_oe, o_wave_out_b, o_wave_out_b_oe;
   logic [31:0] o_prdata;
   logic [2:0] o_irq_req;
   logic [7:0] o_count_value;
   logic pin_a, pin_b, rerr;
   logic [31:0] rdata;
   int n_errors = 0;
   int checked = 0;
   always #4 i_clk = ~i_clk;
   tcu_timer8 tcu_timer8_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_timer_tick(i_timer_tick),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_irq_ack(i_irq_ack),
      .o_irq_req(o_irq_req), .o_count_value(o_count_value), .o_wave_out_a(o_wave_out_a),
      .o_wave_out_a_oe(o_wave_out_a_oe), .o_wave_out_b(o_wave_out_b), .o_wave_out_b_oe(o_wave_out_b_oe));
   tcu_pin_load tcu_pin_load_i (.i_clk(i_clk), .i_drive_a(o_wave_out_a), .i_oe_a(o_wave_out_a_oe),
      .i_drive_b(o_wave_out_b), .i_oe_b(o_wave_out_b_oe), .o_level_a(pin_a), .o_level_b(pin_b));
   ////////////////////////////////////////////////////////////
   task end_sim;
      if (n_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // tk raises a tick in the access cycle so it lands on the write edge
   task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic tk);
      int n;
      n = 0;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr_en;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      i_timer_tick <= tk;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rdata = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      i_timer_tick <= 1'b0;
      if (o_pready !== 1'b1) begin
         n_errors++;
         end_sim();
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
      cmp({31'h0, rerr}, 32'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
      apb(1'b0, a, 32'h0, 1'b0);
      cmp(rdata, exp);
      cmp({31'h0, rerr}, {31'h0, eerr});
   endtask
   task tick;
      @(posedge i_clk);
      i_timer_tick <= 1'b1;
      @(posedge i_clk);
      i_timer_tick <= 1'b0;
   endtask
   task pin_is(input logic exp);
      repeat (2) @(posedge i_clk);
      cmp({31'h0, pin_a}, {31'h0, exp});
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      cmp({30'h0, o_wave_out_a, o_wave_out_b}, 32'h0);
      rd(CNT, 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      rd(8'h02, 32'h0, 1'b1);
      wr(CNT, 32'h55);
      repeat (3) tick();
      rd(CNT, 32'h55, 1'b0);
      wr(MSK, 32'h1);
      wr(CTB, 32'h1);
      wr(CNT, 32'hFE);
      repeat (2) tick();
      rd(CNT, 32'h00, 1'b0);
      rd(FLG, 32'h1, 1'b0);
      cmp({29'h0, o_irq_req}, 32'h1);
      wr(FLG, 32'h1);
      rd(FLG, 32'h0, 1'b0);
      tick();
      rd(FLG, 32'h6, 1'b0);
      cmp({29'h0, o_irq_req}, 32'h0);
      wr(MSK, 32'h7);
      repeat (2) @(posedge i_clk);
      cmp({29'h0, o_irq_req}, 32'h6);
      @(posedge i_clk);
      i_irq_ack <= 3'h2;
      @(posedge i_clk);
      i_irq_ack <= 3'h0;
      rd(FLG, 32'h4, 1'b0);
      wr(FLG, 32'h4);
      // counter written equal to compare: the next tick must not flag
      wr(CMA, 32'h10);
      wr(CNT, 32'h10);
      tick();
      rd(FLG, 32'h0, 1'b0);
      rd(CNT, 32'h11, 1'b0);
      wr(CNT, 32'h0F);
      tick();
      rd(FLG, 32'h0, 1'b0);
      tick();
      rd(FLG, 32'h2, 1'b0);
      wr(FLG, 32'h7);
      apb(1'b1, CNT, 32'h77, 1'b1);
      rd(CNT, 32'h77, 1'b0);
      cmp({24'h0, o_count_value}, 32'h77);
      // wave state is set up with the pin still an input
      wr(CTA, 32'h40);
      wr(CTB, 32'h81);
      wr(PIN, 32'h1);
      pin_is(1'b1);
      rd(CNT, 32'h77, 1'b0);
      rd(FLG, 32'h0, 1'b0);
      wr(CTA, 32'h80);
      wr(CTB, 32'h81);
      pin_is(1'b0);
      wr(CTA, 32'hC0);
      wr(CTB, 32'h81);
      pin_is(1'b1);
      wr(CTA, 32'h40);
      wr(CTB, 32'h81);
      pin_is(1'b0);
      wr(PIN, 32'h5);
      wr(CTA, 32'h00);
      wr(CTB, 32'h81);
      pin_is(1'b1);
      wr(CTA, 32'h40);
      pin_is(1'b0);
      wr(PIN, 32'h0);
      repeat (2) @(posedge i_clk);
      cmp({31'h0, o_wave_out_a_oe}, 32'h0);
      wr(CTA, 32'hC0);
      wr(CTB, 32'h81);
      wr(PIN, 32'h1);
      wr(CTA, 32'h42);
      pin_is(1'b1);
      // channel b: set action, forced while clear-on-match keeps it non-pwm
      wr(CTA, 32'h72);
      wr(CTB, 32'h41);
      wr(PIN, 32'h3);
      repeat (2) @(posedge i_clk);
      cmp({30'h0, pin_b, o_wave_out_b_oe}, 32'h3);
      // clear-on-match: top is compare a, toggle on the match
      wr(CMA, 32'h05);
      wr(CMB, 32'h30);
      wr(CNT, 32'h04);
      repeat (2) tick();
      rd(CNT, 32'h00, 1'b0);
      pin_is(1'b0);
      wr(CTA, 32'h03);
      wr(CMB, 32'h22);
      rd(CMB, 32'h22, 1'b0);
      wr(FLG, 32'h7);
      wr(CNT, 32'h20);
      repeat (3) tick();
      rd(FLG, 32'h0, 1'b0);
      wr(CNT, 32'hFF);
      // second tick finds the counter at bottom, where the buffer is copied
      repeat (2) tick();
      wr(FLG, 32'h7);
      wr(CNT, 32'h21);
      repeat (2) tick();
      rd(FLG, 32'h4, 1'b0);
      end_sim();
   end
endmodule // tcu_timer8_tb
`default_nettype wire
